// ===== spdp_defs.vh
// Constants for the serdes parallel data port: register map, fields, sizes
`ifndef SPDP_DEFS_VH
`define SPDP_DEFS_VH

// ============================================================
// Register offsets (byte addresses)
`define SPDP_REG_CTRL        8'h00
`define SPDP_REG_STAT        8'h04
`define SPDP_REG_ERRCNT      8'h08
`define SPDP_REG_WORDCNT     8'h0c

// ============================================================
// Control register fields
`define SPDP_CTRL_CODE_EN    0
`define SPDP_CTRL_DDR        1
`define SPDP_CTRL_PD         15
`define SPDP_CTRL_RESET      32'h0000_0000
`define SPDP_CTRL_MASK       32'h0000_8003

// ============================================================
// Status register fields
`define SPDP_STAT_TX_RD      0
`define SPDP_STAT_RX_RD      1
`define SPDP_STAT_PD         2
`define SPDP_STAT_IN_RESET   3
`define SPDP_STAT_RX_ERR     4

// ============================================================
// Word and symbol sizes
`define SPDP_WORD_BITS       20
`define SPDP_SYM_BITS        10
`define SPDP_CNT_BITS        16

`endif

// ===== spdp_word_clk.v
// Bit counter that marks word boundaries and makes the receive word clock
`timescale 1ns/100ps
`include "spdp_defs.vh"

module spdp_word_clk
#(
    parameter WORD_BITS = `SPDP_WORD_BITS
)
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_reset,
    // Mode
    input  wire       i_ddr,
    // Timing outputs
    output wire       o_last_bit,
    output reg        o_word_clk
);

    localparam [5:0] LAST = WORD_BITS - 1;
    localparam [5:0] HALF = WORD_BITS / 2;

    reg  [5:0] bit_cnt;
    reg        ddr_q;
    wire [5:0] next_bit_cnt;
    wire       mode_take;
    reg        next_word_clk;

    assign o_last_bit   = (bit_cnt == LAST);
    assign next_bit_cnt = o_last_bit ? 6'h00 : bit_cnt + 6'h01;
    // Rate change waits for a boundary with the clock low, where both shapes rise,
    // so a half period is never cut short or stretched by a mode write
    assign mode_take    = o_last_bit & ~o_word_clk;

    // ============================================================
    // Clock shape: SDR one period per word, DDR one period per two words
    always @*
    begin
        if (ddr_q)
            next_word_clk = o_last_bit ? ~o_word_clk : o_word_clk;
        else
            next_word_clk = (next_bit_cnt < HALF);
    end

    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            bit_cnt    <= 6'h00;
            ddr_q      <= 1'b0;
            o_word_clk <= 1'b0;
        end
        else
        begin
            bit_cnt    <= next_bit_cnt;
            o_word_clk <= next_word_clk;
            if (mode_take)
                ddr_q  <= i_ddr;
        end
    end

endmodule

// ===== spdp_codec.v
// Two-symbol 8b/10b encoder and decoder with running disparity chaining
`timescale 1ns/100ps
`include "spdp_defs.vh"

module spdp_codec
(
    // Transmit side
    input  wire [19:0] i_tx_word,
    input  wire        i_tx_rd,
    output wire [19:0] o_tx_code,
    output wire        o_tx_rd,
    // Receive side
    input  wire [19:0] i_rx_code,
    input  wire        i_rx_rd,
    output wire [19:0] o_rx_word,
    output wire        o_rx_rd
);

    // Negative-disparity code tables, entry 0 in the low bits
    localparam [191:0] C6_D = {6'h2b, 6'h1e, 6'h2e, 6'h0e, 6'h36, 6'h16, 6'h26, 6'h33,
                               6'h3a, 6'h1a, 6'h2a, 6'h0b, 6'h32, 6'h13, 6'h23, 6'h1b,
                               6'h17, 6'h1c, 6'h2c, 6'h0d, 6'h34, 6'h15, 6'h25, 6'h39,
                               6'h38, 6'h19, 6'h29, 6'h35, 6'h31, 6'h2d, 6'h1d, 6'h27};
    localparam [31:0]  C4_D = {4'he, 4'h6, 4'ha, 4'hd, 4'hc, 4'h5, 4'h9, 4'hb};
    localparam [31:0]  C4_K = {4'h7, 4'h9, 4'h5, 4'hd, 4'hc, 4'ha, 4'h6, 4'hb};

    function [3:0] pop10;
        input [9:0] v;
        integer j;
        begin
            pop10 = 4'h0;
            for (j = 0; j < 10; j = j + 1)
                pop10 = pop10 + {3'h0, v[j]};
        end
    endfunction

    // Returns {disparity after, code}; only K28.y and Kx.7 are real control codes
    function [10:0] enc;
        input       k;
        input [7:0] d;
        input       rd;
        reg   [5:0] c6;
        reg   [3:0] c4;
        reg         rd_mid;
        reg         k28;
        reg         alt;
        begin
            k28 = k && (d[4:0] == 5'h1c);
            c6  = k28 ? 6'h0f : C6_D[d[4:0]*6 +: 6];
            if (rd && (pop10({4'h0, c6}) != 4'h3 || d[4:0] == 5'h07))
                c6 = ~c6;
            rd_mid = rd ^ (pop10({4'h0, c6}) != 4'h3);
            alt = (d[7:5] == 3'h7) && (k || (!rd_mid && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14))
                  || (rd_mid && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e)));
            c4 = k28 ? C4_K[d[7:5]*4 +: 4] : (alt ? 4'h7 : C4_D[d[7:5]*4 +: 4]);
            if (rd_mid && (pop10({6'h00, c4}) != 4'h2 || d[7:5] == 3'h3 || k28))
                c4 = ~c4;
            enc = {rd_mid ^ (pop10({6'h00, c4}) != 4'h2), c6, c4};
        end
    endfunction

    // Returns {disparity after, error, k, byte}; a code not legal at this disparity is an error
    function [10:0] dec;
        input [9:0] code;
        input       rd;
        integer i;
        reg  [10:0] e;
        reg         hit;
        reg         rd_hit;
        reg   [8:0] kd;
        begin
            hit    = 1'b0;
            rd_hit = rd;
            kd     = 9'h000;
            for (i = 0; i < 512; i = i + 1)
            begin
                e = enc(i[8], i[7:0], rd);
                if (!hit && e[9:0] == code)
                begin
                    hit    = 1'b1;
                    rd_hit = e[10];
                    kd     = i[8:0];
                end
            end
            if (!hit && pop10(code) != 4'h5)
                rd_hit = (pop10(code) > 4'h5);
            dec = {rd_hit, ~hit, kd};
        end
    endfunction

    wire [10:0] tx_lo = enc(i_tx_word[8], i_tx_word[7:0], i_tx_rd);
    wire [10:0] tx_hi = enc(i_tx_word[18], i_tx_word[17:10], tx_lo[10]);
    wire [10:0] rx_lo = dec(i_rx_code[9:0], i_rx_rd);
    wire [10:0] rx_hi = dec(i_rx_code[19:10], rx_lo[10]);

    // ============================================================
    // Lower symbol first on the line, then the upper one
    assign o_tx_code = {tx_hi[9:0], tx_lo[9:0]};
    assign o_tx_rd   = tx_hi[10];
    assign o_rx_word = {rx_hi[9:0], rx_lo[9:0]};
    assign o_rx_rd   = rx_hi[10];

endmodule

// ===== spdp_top.v
// Parallel data port of one transceiver channel: word capture, serializer, deserializer, pins
// Notes on behaviour
// - Device reset low holds the serial transmit pair at differential zero.
// - Power-down pin low or control power-down bit floats serial and parallel outputs; here the receive word clock, and the bus in device reset, stay driven.
// - Transmit bus is captured on edges of the supplied transmit word clock.
// - Transmit bus carries two symbols per clock in SDR, four in DDR.
// - Receive bus presents two symbols per clock in SDR, four in DDR.
// - Coding off: each transmit half is one encoded 10-bit symbol.
// - Decoding off: each receive half carries one raw 10-bit symbol.
// - Decoding on: low byte 7:0, control flag 8, error flag 9.
// - Decoding on: high byte 17:10, control flag 18, error flag 19.
// - Device reset low drives all twenty receive outputs low.
// - Receive outputs change in step with the receive word clock.
// - Receive word clock runs at bit rate over 20 in SDR, 40 in DDR.
// - Coding off sends transmit bits unmodified; coding on passes them through 8b/10b.
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "spdp_defs.vh"

module spdp_top
#(
    parameter WORD_BITS = `SPDP_WORD_BITS,
    parameter CNT_BITS  = `SPDP_CNT_BITS
)
(
    // Clock and reset; one clock cycle is one serial bit time
    input  wire        i_clk,
    input  wire        i_reset,
    // Register port
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    // Device pins
    input  wire        i_dev_reset_n,
    input  wire        i_chan_powerdown_low,
    // Transmit parallel side
    input  wire        i_tx_word_clock,
    input  wire [19:0] i_tx_par_bus,
    // Serial side
    input  wire        i_serial_rx_pos,
    input  wire        i_serial_rx_neg,
    output reg         o_serial_tx_pos,
    output reg         o_serial_tx_neg,
    output reg         o_serial_tx_oe,
    // Receive parallel side
    output wire        o_rx_word_clock,
    output reg  [19:0] o_rx_par_bus,
    output reg         o_rx_par_oe
);

    // ============================================================
    // Helpers
    function [CNT_BITS-1:0] sat_add;
        input [CNT_BITS-1:0] a;
        input [1:0]          b;
        reg   [CNT_BITS:0]   s;
        begin
            s = {1'b0, a} + {{(CNT_BITS-1){1'b0}}, b};
            sat_add = s[CNT_BITS] ? {CNT_BITS{1'b1}} : s[CNT_BITS-1:0];
        end
    endfunction

    // ============================================================
    // Control state
    reg  [31:0]         ctrl;
    reg  [CNT_BITS-1:0] err_cnt;
    reg  [CNT_BITS-1:0] word_cnt;
    reg                 rx_err_seen;
    wire                code_en  = ctrl[`SPDP_CTRL_CODE_EN];
    wire                ddr_mode = ctrl[`SPDP_CTRL_DDR];
    wire                core_rst = i_reset | ~i_dev_reset_n;
    wire                powerdown = ~i_chan_powerdown_low | ctrl[`SPDP_CTRL_PD];

    // ============================================================
    // Word timing
    wire last_bit;

    spdp_word_clk
    #(
        .WORD_BITS (WORD_BITS)
    )
    u_word_clk
    (
        .i_clk      (i_clk),
        .i_reset    (core_rst),
        .i_ddr      (ddr_mode),
        .o_last_bit (last_bit),
        .o_word_clk (o_rx_word_clock)
    );

    // ============================================================
    // Transmit word capture
    reg         tx_clk_prev;
    reg  [19:0] tx_hold;
    wire        tx_rise = i_tx_word_clock & ~tx_clk_prev;
    wire        tx_fall = ~i_tx_word_clock & tx_clk_prev;
    wire        tx_take = tx_rise | (ddr_mode & tx_fall);

    // A locked word clock gives exactly one capture per serializer word,
    // so a single holding stage is enough and no FIFO is kept.
    // Edges are found by sampling the word clock as data on the bit clock;
    // the previous level resets low, the tied-off level of an unused pin.
    always @(posedge i_clk)
    begin
        if (core_rst)
        begin
            tx_clk_prev <= 1'b0;
            tx_hold     <= 20'h00000;
        end
        else
        begin
            tx_clk_prev <= i_tx_word_clock;
            if (tx_take)
                tx_hold <= i_tx_par_bus;
        end
    end

    // ============================================================
    // Codec
    reg  [19:0] rx_shift;
    reg         tx_rd;
    reg         rx_rd;
    wire [19:0] tx_code;
    wire        next_tx_rd;
    // At the boundary the oldest of the twenty bits sits in rx_shift[18],
    // because the current line bit has not been shifted in yet.
    wire [19:0] rx_raw = {rx_shift[8:0], i_serial_rx_pos, rx_shift[18:9]};
    wire [19:0] rx_dec;
    wire        next_rx_rd;

    spdp_codec u_codec
    (
        .i_tx_word (tx_hold),
        .i_tx_rd   (tx_rd),
        .o_tx_code (tx_code),
        .o_tx_rd   (next_tx_rd),
        .i_rx_code (rx_raw),
        .i_rx_rd   (rx_rd),
        .o_rx_word (rx_dec),
        .o_rx_rd   (next_rx_rd)
    );

    // ============================================================
    // Serializer: lower symbol first, each symbol sent from its top bit
    // The pair is always complementary outside reset; a floated pair is
    // shown only through the output enable, never by a forced level.
    reg  [19:0] tx_shift;
    wire [19:0] tx_sym = code_en ? tx_code : tx_hold;
    wire [19:0] next_tx_shift = last_bit ? {tx_sym[9:0], tx_sym[19:10]} : {tx_shift[18:0], 1'b0};

    always @(posedge i_clk)
    begin
        if (core_rst)
        begin
            tx_shift        <= 20'h00000;
            tx_rd           <= 1'b0;
            o_serial_tx_pos <= 1'b0;
            o_serial_tx_neg <= 1'b0;
        end
        else
        begin
            tx_shift        <= next_tx_shift;
            o_serial_tx_pos <= next_tx_shift[19];
            o_serial_tx_neg <= ~next_tx_shift[19];
            if (last_bit && code_en)
                tx_rd <= next_tx_rd;
        end
    end

    // ============================================================
    // Deserializer and receive word output
    // No comma alignment here: word boundaries follow the local bit count.
    // Limitation: a far end whose bit phase differs sees shifted symbols
    // and, with coding on, a burst of code errors until it realigns.
    // Disparity is carried only across words that were decoded.
    wire [19:0] rx_word = code_en ? rx_dec : rx_raw;
    wire [1:0]  rx_errs = {1'b0, rx_dec[19]} + {1'b0, rx_dec[9]};

    always @(posedge i_clk)
    begin
        if (core_rst)
        begin
            rx_shift     <= 20'h00000;
            rx_rd        <= 1'b0;
            o_rx_par_bus <= 20'h00000;
        end
        else
        begin
            rx_shift <= {rx_shift[18:0], i_serial_rx_pos};
            if (last_bit)
            begin
                o_rx_par_bus <= rx_word;
                if (code_en)
                    rx_rd <= next_rx_rd;
            end
        end
    end

    // ============================================================
    // Output enables; the clock pin itself is never floated
    // Device reset keeps the receive bus driven so that the far end
    // sees a defined low word instead of a floating bus.
    // Power down with device reset high, or the full reset, drops both enables at once.
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_serial_tx_oe <= 1'b0;
            o_rx_par_oe    <= 1'b0;
        end
        else
        begin
            o_serial_tx_oe <= ~powerdown;
            o_rx_par_oe    <= ~powerdown | ~i_dev_reset_n;
        end
    end

    // ============================================================
    // Register port
    wire wr_ctrl   = i_wr && (i_addr == `SPDP_REG_CTRL);
    wire wr_errcnt = i_wr && (i_addr == `SPDP_REG_ERRCNT);
    wire wr_wdcnt  = i_wr && (i_addr == `SPDP_REG_WORDCNT);
    wire wr_stat   = i_wr && (i_addr == `SPDP_REG_STAT);
    wire rx_event  = last_bit && code_en && !core_rst;
    wire rx_err_ev = rx_event && (rx_errs != 2'h0);

    // Hardware events win over a software clear in the same cycle
    // Counters saturate rather than wrap, so a long error burst
    // can never read back as a small count.
    // Registers survive device reset; only the full reset clears them.
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl        <= `SPDP_CTRL_RESET;
            err_cnt     <= {CNT_BITS{1'b0}};
            word_cnt    <= {CNT_BITS{1'b0}};
            rx_err_seen <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= i_wdata & `SPDP_CTRL_MASK;
            if (rx_err_ev)
                err_cnt <= sat_add(wr_errcnt ? {CNT_BITS{1'b0}} : err_cnt, rx_errs);
            else if (wr_errcnt)
                err_cnt <= {CNT_BITS{1'b0}};
            if (last_bit && !core_rst)
                word_cnt <= sat_add(wr_wdcnt ? {CNT_BITS{1'b0}} : word_cnt, 2'h1);
            else if (wr_wdcnt)
                word_cnt <= {CNT_BITS{1'b0}};
            if (rx_err_ev)
                rx_err_seen <= 1'b1;
            else if (wr_stat && i_wdata[`SPDP_STAT_RX_ERR])
                rx_err_seen <= 1'b0;
        end
    end

    reg [31:0] next_rdata;

    always @*
    begin
        next_rdata = 32'h0000_0000;
        case (i_addr)
            `SPDP_REG_CTRL:
                next_rdata = ctrl;
            `SPDP_REG_STAT:
            begin
                next_rdata[`SPDP_STAT_TX_RD]     = tx_rd;
                next_rdata[`SPDP_STAT_RX_RD]     = rx_rd;
                next_rdata[`SPDP_STAT_PD]        = powerdown;
                next_rdata[`SPDP_STAT_IN_RESET]  = ~i_dev_reset_n;
                next_rdata[`SPDP_STAT_RX_ERR]    = rx_err_seen;
            end
            `SPDP_REG_ERRCNT:
                next_rdata[CNT_BITS-1:0] = err_cnt;
            `SPDP_REG_WORDCNT:
                next_rdata[CNT_BITS-1:0] = word_cnt;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge i_clk)
    begin
        if (i_reset)
            o_rdata <= 32'h0000_0000;
        else if (i_rd)
            o_rdata <= next_rdata;
        else
            o_rdata <= 32'h0000_0000;
    end

endmodule

// ===== spdp_props.sv
// Property checker for the serdes parallel data port pins and word timing
`timescale 1ns/100ps
module spdp_props
(
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_reset,
    // Register write and device pins
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_dev_reset_n,
    input wire logic        i_chan_powerdown_low,
    // Observed outputs
    input wire logic        o_serial_tx_pos,
    input wire logic        o_serial_tx_neg,
    input wire logic        o_serial_tx_oe,
    input wire logic        o_rx_word_clock,
    input wire logic [19:0] o_rx_par_bus,
    input wire logic        o_rx_par_oe
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    // ============================================================
    // Cycles since the receive word clock last moved
    logic [5:0] idle_cnt;
    logic       wclk_q;
    always @(posedge i_clk)
    begin
        wclk_q <= o_rx_word_clock;
        // Device reset parks the clock, so the count restarts there and while the bus is floated
        if (i_reset || !i_dev_reset_n || !o_rx_par_oe || o_rx_word_clock != wclk_q)
            idle_cnt <= 6'h00;
        else
            idle_cnt <= idle_cnt + 6'h01;
    end

    // ============================================================
    // Assertions
    AST_DEVRST_TX_ZERO: assert property (!i_dev_reset_n |=> !o_serial_tx_pos && !o_serial_tx_neg)
        else $error("serial pair not at zero in device reset");
    AST_DEVRST_RX_LOW: assert property (!i_dev_reset_n |=> o_rx_par_bus == 20'h00000 && o_rx_par_oe)
        else $error("receive bus not driven low in device reset");
    AST_PD_PIN_FLOAT: assert property (!i_chan_powerdown_low && i_dev_reset_n |=> !o_serial_tx_oe && !o_rx_par_oe)
        else $error("outputs still driven with power-down pin low");
    AST_PD_REG_FLOAT: assert property (i_wr && i_addr == 8'h00 && i_wdata[15] ##1 i_dev_reset_n |=> !o_serial_tx_oe)
        else $error("serial output driven after power-down bit set");
    AST_TX_COMPLEMENT: assert property (o_serial_tx_oe && $past(i_dev_reset_n) |-> o_serial_tx_neg != o_serial_tx_pos)
        else $error("serial pair not complementary");
    AST_RX_ON_CLOCK: assert property ($changed(o_rx_par_bus) && $past(i_dev_reset_n) |-> $changed(o_rx_word_clock))
        else $error("receive bus moved without a word clock edge");
    AST_RX_WORD_HOLD: assert property ($changed(o_rx_par_bus) && $past(i_dev_reset_n)
        |=> ($stable(o_rx_par_bus) || !$past(i_dev_reset_n))[*8])
        else $error("receive word held too briefly");
    AST_WCLK_MIN_HALF: assert property ($changed(o_rx_word_clock) && $past(i_dev_reset_n)
        |=> ($stable(o_rx_word_clock) || !$past(i_dev_reset_n))[*8])
        else $error("receive word clock half period too short");
    AST_WCLK_MAX_HALF: assert property (idle_cnt <= 6'd20)
        else $error("receive word clock stalled");

    COV_WCLK_RISE: cover property ($rose(o_rx_word_clock));
    COV_POWER_DOWN: cover property ($fell(o_serial_tx_oe));
    COV_DEV_RESET: cover property ($fell(i_dev_reset_n));
endmodule

bind spdp_top spdp_props u_props (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_dev_reset_n,
    .i_chan_powerdown_low, .o_serial_tx_pos, .o_serial_tx_neg, .o_serial_tx_oe, .o_rx_word_clock,
    .o_rx_par_bus, .o_rx_par_oe);

// ===== spdp_far_end.sv
// Far-end logic model that drives the transmit word clock and transmit bus
`timescale 1ns/100ps
module spdp_far_end
(
    // Clock and control
    input  wire logic        i_clk,
    input  wire logic        i_run,
    input  wire logic        i_ddr,
    input  wire logic        i_coding,
    input  wire logic [19:0] i_word,
    // Transmit pins of the port
    output logic             o_tx_word_clock,
    output logic [19:0]      o_tx_par_bus
);
    logic [5:0] cnt;
    logic       k_lo;
    logic       k_hi;
    // Control flag only on the comma byte, so every symbol is a legal code
    assign k_lo = i_word[8] & i_word[9];
    assign k_hi = i_word[18] & i_word[19];

    // ============================================================
    // Clock locked to the bit clock: one word per 20 bit times in both modes
    always @(posedge i_clk)
    begin
        if (!i_run)
        begin
            cnt             <= 6'h00;
            o_tx_word_clock <= 1'b0;
            o_tx_par_bus    <= 20'h00000;
        end
        else if (cnt == (i_ddr ? 6'd19 : 6'd9))
        begin
            cnt             <= 6'h00;
            o_tx_word_clock <= ~o_tx_word_clock;
            if (i_ddr || !o_tx_word_clock)
                o_tx_par_bus <= i_coding ? {1'b0, k_hi, k_hi ? 8'hbc : i_word[17:10],
                                            1'b0, k_lo, k_lo ? 8'hbc : i_word[7:0]}
                                         : i_word;
        end
        else
            cnt <= cnt + 6'h01;
    end
endmodule

// ===== test_spdp_top.sv
// Self-checking testbench for the serdes parallel data port with serial loopback
`timescale 1ns/100ps
module test_spdp_top;
    logic        i_clk, i_reset, i_wr, i_rd, i_dev_reset_n, i_chan_powerdown_low;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, rnd, rv;
    logic        run, ddr, code, garbage, chk_on, synced, txc_q, wclk_q;
    logic [19:0] sh;
    logic [19:0] sent[$];
    wire         tx_pos, tx_neg, tx_oe, wclk, rx_oe, txc, rx_in;
    wire  [19:0] rx_bus, txbus;
    wire  [31:0] o_rdata;
    integer      num_errors, tests_run, seed, i, m;

    assign rx_in = garbage ? rnd[20] : tx_pos;

    spdp_top DUT (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_dev_reset_n(i_dev_reset_n),
        .i_chan_powerdown_low(i_chan_powerdown_low), .i_tx_word_clock(txc), .i_tx_par_bus(txbus),
        .i_serial_rx_pos(rx_in), .i_serial_rx_neg(~rx_in), .o_serial_tx_pos(tx_pos),
        .o_serial_tx_neg(tx_neg), .o_serial_tx_oe(tx_oe), .o_rx_word_clock(wclk),
        .o_rx_par_bus(rx_bus), .o_rx_par_oe(rx_oe));
    spdp_far_end u_far (.i_clk(i_clk), .i_run(run), .i_ddr(ddr), .i_coding(code), .i_word(rnd[19:0]),
        .o_tx_word_clock(txc), .o_tx_par_bus(txbus));

    // ============================================================
    // Shared tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rv = o_rdata;
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ============================================================
    // Reference model: words taken by the port and bits seen on the line
    always @(posedge i_clk)
    begin
        rnd <= $random(seed);
        if (txc != txc_q && (ddr || txc))
            sent.push_back(txbus);
        txc_q = txc;
        sh = {sh[18:0], rx_in};
        #1;
        if (chk_on && (wclk != wclk_q) && (ddr || wclk))
        begin
            if (!code)
                check("rx_raw", rx_bus, {sh[9:0], sh[19:10]});
            if (synced && sent.size() > 0)
                check("rx_word", rx_bus, sent.pop_front());
            for (i = 0; !synced && i < sent.size(); i++)
                if (sent[i] === rx_bus)
                begin
                    synced = 1'b1;
                    sent = sent[i+1:$];
                end
        end
        wclk_q = wclk;
    end

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial
    begin
        repeat (40000) @(posedge i_clk);
        num_errors = num_errors + 1;
        report_and_stop;
    end

    initial
    begin
        {i_wr, i_rd, run, ddr, code, garbage, chk_on, synced, txc_q, wclk_q} = 10'h000;
        {i_addr, i_wdata, rnd, sh, num_errors, tests_run} = 0;
        seed = 32'hb40c0768;
        i_reset = 1'b1;
        i_dev_reset_n = 1'b1;
        i_chan_powerdown_low = 1'b1;
        repeat (20) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(8'h00);
        check("ctrl_reset", rv, 32'h0);
        rd(8'h10);
        check("unmapped", rv, 32'h0);
        // All four coding and rate modes through the loopback
        for (m = 0; m < 4; m++)
        begin
            chk_on = 1'b0;
            run <= 1'b0;
            wr(8'h00, m);
            {ddr, code} = {m[1], m[0]};
            run <= 1'b1;
            // Word clock takes a new rate only at a later boundary
            repeat (60) @(posedge i_clk);
            sent.delete();
            synced = 1'b0;
            chk_on = 1'b1;
            repeat (300) @(posedge i_clk);
            check("sync", synced, 1);
        end
        // Line garbage in coding mode must raise the code error flag
        chk_on = 1'b0;
        garbage = 1'b1;
        repeat (200) @(posedge i_clk);
        garbage = 1'b0;
        repeat (200) @(posedge i_clk);
        rd(8'h04);
        check("err_sticky", rv[4], 1);
        wr(8'h04, 32'h10);
        wr(8'h08, 32'h0);
        rd(8'h04);
        check("err_clear", rv[4], 0);
        rd(8'h08);
        check("err_count", rv, 32'h0);
        // Register and pin power down
        wr(8'h00, 32'hffffffff);
        repeat (3) @(posedge i_clk);
        check("pd_reg_oe", {tx_oe, rx_oe}, 0);
        rd(8'h00);
        check("ctrl_mask", rv, 32'h8003);
        rd(8'h04);
        check("stat_pd", rv[2], 1);
        wr(8'h00, 32'h1);
        i_chan_powerdown_low <= 1'b0;
        repeat (3) @(posedge i_clk);
        check("pd_pin_oe", {tx_oe, rx_oe}, 0);
        i_chan_powerdown_low <= 1'b1;
        repeat (40) @(posedge i_clk);
        // Device reset
        i_dev_reset_n <= 1'b0;
        repeat (3) @(posedge i_clk);
        #1 check("devrst_tx", {tx_pos, tx_neg}, 0);
        check("devrst_rx", rx_bus, 0);
        rd(8'h04);
        check("stat_devrst", rv[3], 1);
        i_dev_reset_n <= 1'b1;
        repeat (60) @(posedge i_clk);
        report_and_stop;
    end
endmodule
